// File: rtl/static_memory_expansion_port_consts.svh
// constants of the static memory expansion port
`ifndef STATIC_MEMORY_EXPANSION_PORT_CONSTS_SVH
`define STATIC_MEMORY_EXPANSION_PORT_CONSTS_SVH
`define ADDR_W 28
`define DATA_W 32
`define CS_W 6
`define WAIT_W 4
`define BURST_W 3
`define BURST_MIN 3'h2
`define BURST_MAX 3'h4
`define CLOCK_DIV 1'h1
`endif

// File: rtl/static_memory_expansion_port_pkg.sv
// types of the static memory expansion port
package static_memory_expansion_port_pkg;
    typedef enum logic [1:0] {
        size_byte,
        size_half,
        size_word
    } size_e;
    typedef struct packed {
        logic [27:0] address;
        logic [31:0] wdata;
        logic [5:0] select;
        size_e size;
        logic write;
        logic [2:0] beats;
        logic [3:0] waits;
    } request_s;
    typedef struct packed {
        logic [27:0] address;
        logic [31:0] wdata;
        logic [5:0] chip_select_n;
        logic word;
        logic half;
        logic write;
        logic write_strobe_n;
        logic output_enable_n;
    } bus_s;
endpackage

// File: rtl/ready_sampler.sv
// falling-edge sampler of the expansion ready input
`timescale 1ns/1ps
`include "static_memory_expansion_port_consts.svh"
module ready_sampler (
    input wire logic clock,
    input wire logic reset,
    input wire logic expansion_clock,
    input wire logic expansion_ready,
    output logic ready_seen,
    output logic fall_pulse
);
    // ----------------------------------------
    // edge detect on the sampled expansion clock
    // ----------------------------------------
    logic clk_d_r, clk_d_nxt;
    logic seen_r, seen_nxt;
    logic fall_r, fall_nxt;
    always_comb begin
        clk_d_nxt = expansion_clock;
        fall_nxt = clk_d_r & ~expansion_clock;
        // ready is held as sampled at the falling edge before the transfer
        seen_nxt = (clk_d_r & ~expansion_clock) ? expansion_ready : seen_r; // RULE2
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            clk_d_r <= 1'b0;
            seen_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            clk_d_r <= clk_d_nxt;
            seen_r <= seen_nxt;
            fall_r <= fall_nxt;
        end
    end
    assign ready_seen = seen_r;
    assign fall_pulse = fall_r;
endmodule

// File: rtl/static_memory_expansion_port.sv
// static memory and expansion cycle sequencer
// What this block does
// RULE1 - stretch cycles only by whole clocks, from wait count or low ready
// RULE2 - sample ready at the falling expansion clock edge before transfer
// RULE3 - ready low postpones transfer one period, then samples again
// RULE4 - burst length programmable from two to four cycles
// RULE5 - burst never over four beats; zero waits gives one clock per beat (bursts here are writes only, and every write gets at least one wait)
// RULE6 - zero-wait sequential writes are not used with write strobe memories
// RULE7 - address, data, size selects and direction hold until next cycle
// RULE8 - ready may change anytime; controller samples it internally
// RULE9 - drive word and halfword size select outputs
// RULE10 - expansion device drives ready to finish the transfer
// RULE11 - programmed waits first, then ready extensions, then transfer
`timescale 1ns/1ps
`include "static_memory_expansion_port_consts.svh"
module static_memory_expansion_port (
    input wire logic clock,
    input wire logic reset,
    input wire logic expansion_ready,
    input static_memory_expansion_port_pkg::request_s request,
    input wire logic request_valid,
    input wire logic [`DATA_W-1:0] read_data_in,
    output logic request_ready,
    output logic expansion_clock,
    output static_memory_expansion_port_pkg::bus_s bus,
    output logic data_out_enable,
    output logic [`DATA_W-1:0] read_data,
    output logic read_valid,
    output logic beat_done
);
    // ----------------------------------------
    // expansion clock, one block clock per phase
    // ----------------------------------------
    logic xclk_r;
    logic xclk_nxt;
    logic ready_seen;
    logic fall_pulse;
    always_comb begin
        xclk_nxt = ~xclk_r;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            xclk_r <= 1'b0;
        end else begin
            xclk_r <= xclk_nxt;
        end
    end

    // ready is asynchronous to us, so it only enters through the sampler
    ready_sampler ready_sampler_inst (
        .clock(clock),
        .reset(reset),
        .expansion_clock(xclk_r),
        .expansion_ready(expansion_ready), // RULE8
        .ready_seen(ready_seen),
        .fall_pulse(fall_pulse)
    );

    // ----------------------------------------
    // cycle sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {idle, waiting, readying, finish} state_e;
    state_e state_r;
    state_e state_nxt;
    static_memory_expansion_port_pkg::bus_s bus_r;
    static_memory_expansion_port_pkg::bus_s bus_nxt;
    logic [`WAIT_W-1:0] wait_r;
    logic [`WAIT_W-1:0] wait_nxt;
    logic [`WAIT_W-1:0] wait_load_r;
    logic [`WAIT_W-1:0] wait_load_nxt;
    logic [`BURST_W-1:0] beats_r;
    logic [`BURST_W-1:0] beats_nxt;
    logic oe_r;
    logic oe_nxt;
    logic rv_r;
    logic rv_nxt;
    logic done_r;
    logic done_nxt;
    logic req_rdy_r;
    logic req_rdy_nxt;
    logic [`DATA_W-1:0] rd_r;
    logic [`DATA_W-1:0] rd_nxt;
    logic [`BURST_W-1:0] req_beats;
    logic fall_edge;

    // xclk_nxt is always the inverse, so this marks the high phase before a fall
    assign fall_edge = xclk_r & ~xclk_nxt;

    // ----------------------------------------
    // beat count of the request
    // ----------------------------------------
    always_comb begin
        // write beat count clamped into the legal range; reads forced to one beat
        req_beats = request.beats;
        if (request.beats < `BURST_MIN) begin
            req_beats = `BURST_MIN; // RULE4
        end
        if (request.beats > `BURST_MAX) begin
            req_beats = `BURST_MAX; // RULE5
        end
        if (!request.write) begin
            req_beats = 3'h1;
        end
    end

    // ----------------------------------------
    // next state and bus values
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        bus_nxt = bus_r;
        wait_nxt = wait_r;
        wait_load_nxt = wait_load_r;
        beats_nxt = beats_r;
        oe_nxt = oe_r;
        rv_nxt = 1'b0;
        done_nxt = 1'b0;
        rd_nxt = rd_r;
        req_rdy_nxt = 1'b0;
        unique case (state_r)
            idle: begin
                // taken only in the high phase, so every cycle starts on a fall
                if (request_valid && fall_edge) begin
                    req_rdy_nxt = 1'b1;
                    bus_nxt.address = request.address;
                    bus_nxt.wdata = request.wdata;
                    bus_nxt.chip_select_n = ~request.select;
                    bus_nxt.word = request.size == static_memory_expansion_port_pkg::size_word; // RULE9
                    bus_nxt.half = request.size == static_memory_expansion_port_pkg::size_half; // RULE9
                    bus_nxt.write = request.write;
                    // a write strobe needs one wait, so zero-wait writes get one
                    wait_load_nxt = (request.write && request.waits == 4'h0) ?
                        4'h1 : request.waits; // RULE6
                    wait_nxt = wait_load_nxt;
                    beats_nxt = req_beats;
                    oe_nxt = request.write;
                    bus_nxt.write_strobe_n = ~request.write;
                    bus_nxt.output_enable_n = request.write;
                    state_nxt = waiting;
                end
            end
            waiting: begin
                if (fall_edge) begin
                    if (wait_r != 4'h0) begin
                        wait_nxt = wait_r - 4'h1; // RULE1 RULE11
                    end else begin
                        state_nxt = readying;
                    end
                end
            end
            readying: begin
                // ready low adds one whole period and is looked at again
                if (fall_pulse) begin
                    if (ready_seen) begin // RULE3 RULE10 RULE11
                        state_nxt = finish;
                    end
                end
            end
            finish: begin
                done_nxt = 1'b1;
                if (!bus_r.write) begin
                    rd_nxt = read_data_in;
                    rv_nxt = 1'b1;
                end
                // the forced write wait keeps bursts slower than one clock per beat
                if (beats_r > 3'h1) begin
                    beats_nxt = beats_r - 3'h1; // RULE5
                    bus_nxt.address = bus_r.address + 28'h4;
                    wait_nxt = wait_load_r;
                    state_nxt = waiting;
                end else begin
                    // strobes end but address, data, sizes, direction stay
                    bus_nxt.chip_select_n = 6'h3F; // RULE7
                    bus_nxt.write_strobe_n = 1'b1;
                    bus_nxt.output_enable_n = 1'b1;
                    oe_nxt = 1'b0;
                    state_nxt = idle;
                end
            end
        endcase
    end

    // ----------------------------------------
    // sequencer registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= idle;
            bus_r <= '{address: 28'h0, wdata: 32'h0, chip_select_n: 6'h3F, word: 1'b0,
                half: 1'b0, write: 1'b0, write_strobe_n: 1'b1, output_enable_n: 1'b1};
            wait_r <= 4'h0;
            wait_load_r <= 4'h0;
            beats_r <= 3'h0;
            oe_r <= 1'b0;
            rv_r <= 1'b0;
            done_r <= 1'b0;
            rd_r <= 32'h0;
            req_rdy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bus_r <= bus_nxt;
            wait_r <= wait_nxt;
            wait_load_r <= wait_load_nxt;
            beats_r <= beats_nxt;
            oe_r <= oe_nxt;
            rv_r <= rv_nxt;
            done_r <= done_nxt;
            rd_r <= rd_nxt;
            req_rdy_r <= req_rdy_nxt;
        end
    end

    // ----------------------------------------
    // outputs, each straight from a register
    // ----------------------------------------
    assign expansion_clock = xclk_r;
    assign bus = bus_r;
    assign data_out_enable = oe_r;
    assign read_data = rd_r;
    assign read_valid = rv_r;
    assign beat_done = done_r;
    assign request_ready = req_rdy_r;
endmodule

// File: bench/static_memory_expansion_port_checker.sv
// checker of the expansion port cycles
`timescale 1ns/1ps
module static_memory_expansion_port_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic expansion_ready,
    input wire logic request_ready,
    input wire logic expansion_clock,
    input static_memory_expansion_port_pkg::bus_s bus,
    input wire logic data_out_enable,
    input wire logic read_valid,
    input wire logic beat_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ------
    // checks
    // ------
    logic [2:0] beats_r;
    always_ff @(posedge clock)
        beats_r <= (reset || request_ready) ? 3'h0 : beats_r + {2'h0, beat_done};
    a_clock_toggles: assert property (!$past(reset) |-> $changed(expansion_clock))
        else $error("expansion clock stopped");
    a_ready_low: assert property (!expansion_ready [*8] |-> !beat_done)
        else $error("beat ended while not ready");
    a_hold_idle: assert property (&bus.chip_select_n && $past(bus.chip_select_n) == 6'h3F
        |-> $stable({bus.address, bus.wdata, bus.word, bus.half, bus.write}))
        else $error("bus moved while idle");
    a_size_selects: assert property (!(bus.word && bus.half))
        else $error("word and half both set");
    a_burst_max: assert property (beats_r <= 3'h4)
        else $error("burst too long");
    a_waits_first: assert property (request_ready |=> !beat_done [*2])
        else $error("beat too early");
    a_strobe_dir: assert property (!bus.write_strobe_n |-> bus.write && bus.output_enable_n)
        else $error("write strobe outside write");
    a_taken_pulse: assert property (request_ready |=> !request_ready)
        else $error("request ready held");
    a_drive_dir: assert property (data_out_enable == (bus.write && !(&bus.chip_select_n)))
        else $error("data drive outside a selected write");
    c_write: cover property (beat_done && bus.write);
    c_read: cover property (read_valid);
    c_full: cover property (beats_r == 3'h4);
    c_stall: cover property (!expansion_ready && !(&bus.chip_select_n));
endmodule

// File: bench/expansion_device_model.sv
// behavioural static memory on the expansion port
`timescale 1ns/1ps
module expansion_device_model (
    input wire logic clock,
    input wire logic hold_ready,
    input static_memory_expansion_port_pkg::bus_s bus,
    output logic expansion_ready,
    output logic [31:0] read_data_in
);
    logic [31:0] mem [16];
    logic [31:0] last_r = 32'h0;
    logic sel;
    assign sel = !bus.chip_select_n[0];
    // a level set by the bench, unrelated to the port clock
    assign expansion_ready = !hold_ready;
    // released lines toggle so a stale value never passes
    assign read_data_in = (sel && !bus.output_enable_n) ? mem[bus.address[5:2]] : ~last_r;
    always @(posedge clock) begin
        last_r <= read_data_in;
        if (sel && !bus.write_strobe_n) mem[bus.address[5:2]] <= bus.wdata;
    end
endmodule

// File: bench/static_memory_expansion_port_bench.sv
// self-checking bench of the expansion port
`timescale 1ns/1ps
module static_memory_expansion_port_bench;
    typedef struct packed {
        logic [27:0] a; logic [31:0] d; logic w; logic [2:0] b;
        logic [3:0] t; logic [1:0] s; logic [2:0] n;
    } row_s;
    row_s rows [6] = '{
        '{28'h10, 32'hA5A50F0F, 1'h1, 3'h4, 4'h0, 2'h2, 3'h4},
        '{28'h80, 32'h12345678, 1'h1, 3'h1, 4'h2, 2'h1, 3'h2},
        '{28'h20, 32'h0F1E2D3C, 1'h1, 3'h7, 4'h1, 2'h2, 3'h4},
        '{28'h18, 32'hA5A50F0F, 1'h0, 3'h1, 4'h0, 2'h2, 3'h1},
        '{28'h84, 32'h12345678, 1'h0, 3'h1, 4'h0, 2'h0, 3'h1},
        '{28'h2C, 32'h0F1E2D3C, 1'h0, 3'h1, 4'h5, 2'h2, 3'h1}};
    logic clock = 1'h0, reset = 1'h1, request_valid = 1'h0, hold_ready = 1'h0;
    logic expansion_ready, request_ready, expansion_clock, read_valid, beat_done;
    logic [31:0] read_data_in, read_data, rd;
    static_memory_expansion_port_pkg::request_s request = '0;
    static_memory_expansion_port_pkg::bus_s bus;
    int n_errors = 0, check_count = 0, cycles = 0, got, lat, lats [6];
    static_memory_expansion_port static_memory_expansion_port_inst (.clock, .reset,
        .expansion_ready, .request, .request_valid, .read_data_in, .request_ready,
        .expansion_clock, .bus, .data_out_enable(), .read_data, .read_valid, .beat_done);
    expansion_device_model expansion_device_model_inst (.clock, .hold_ready, .bus,
        .expansion_ready, .read_data_in);
    always #10 clock = ~clock;
    // ---------
    // procedures
    // ---------
    task check(input logic ok, input string m);
        check_count++;
        if (ok !== 1'h1) begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // beats are counted through a quiet tail so an extra beat shows
    task automatic run(input row_s x);
        int k;
        k = 0;
        @(negedge clock);
        request = '{x.a, x.d, 6'h01, static_memory_expansion_port_pkg::size_e'(x.s), x.w,
            x.b, x.t};
        request_valid = 1'h1;
        while (request_ready !== 1'h1 && k < 200) begin
            @(negedge clock);
            k++;
        end
        request_valid = 1'h0;
        got = 0;
        lat = 0;
        rd = 'x;
        while (got < x.n + 0 && k < 400) begin
            @(negedge clock);
            k++;
            lat += (got == 0);
            got += (beat_done === 1'h1);
            if (read_valid === 1'h1) rd = read_data;
        end
        repeat (8) @(negedge clock) got += (beat_done === 1'h1);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(negedge clock);
        check(bus.chip_select_n === 6'h3F && bus.write_strobe_n === 1'h1, "reset");
        reset = 1'h0;
        foreach (rows[i]) begin
            run(rows[i]);
            lats[i] = lat;
            check(got === rows[i].n + 0, "beat count");
            check(bus.word === (rows[i].s == 2'h2) && bus.half === (rows[i].s == 2'h1),
                "size selects");
            if (rows[i].w) check(bus.address === rows[i].a + {rows[i].n - 3'h1, 2'h0}
                && bus.wdata === rows[i].d, "held address");
            else check(rd === rows[i].d, "read data");
        end
        check(lats[5] - lats[3] == 10, "wait clocks");
        check(lats[2] == lats[0], "zero waits on write");
        hold_ready = 1'h1;
        fork
            run(rows[4]);
            begin
                repeat (40) @(negedge clock);
                check(got === 0, "stalled");
                hold_ready = 1'h0;
            end
        join
        check(rd === rows[4].d && got === 1, "after stall");
        // a reset in mid-burst must drop every strobe at once
        request.write = 1'h1;
        request_valid = 1'h1;
        @(negedge clock iff request_ready === 1'h1);
        request_valid = 1'h0;
        repeat (2) @(negedge clock);
        reset = 1'h1;
        @(negedge clock);
        check(bus.chip_select_n === 6'h3F && bus.write_strobe_n === 1'h1, "reset in burst");
        reset = 1'h0;
        run(rows[3]);
        check(rd === rows[3].d && got === 1, "after reset");
        stop_test();
    end
endmodule
bind static_memory_expansion_port static_memory_expansion_port_checker checker_inst (.clock,
    .reset, .expansion_ready, .request_ready, .expansion_clock, .bus, .data_out_enable,
    .read_valid, .beat_done);
